// File: hdl/vec_irq_pkg.sv
package vec_irq_pkg;
  localparam int NUM_CH = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;
  localparam logic [3:0] THRESH_MAX = 4'hC;
  localparam logic [3:0] THRESH_RESET = 4'h8;
  localparam int STACK_DEPTH = 3;
  localparam int SYNC_W = 12;

  // Word offsets (byte address bits 7:2)
  localparam logic [5:0] LVEC0_IDX = 6'h00;
  localparam logic [5:0] LVEC1_IDX = 6'h01;
  localparam logic [5:0] RX_LEVEL_IDX = 6'h02;
  localparam logic [5:0] TX_LEVEL_IDX = 6'h03;
  localparam logic [5:0] MODEM_LEVEL_IDX = 6'h04;
  localparam logic [5:0] OPT4_0_IDX = 6'h05;
  localparam logic [5:0] OPT4_1_IDX = 6'h06;
  localparam logic [5:0] MODE0_IDX = 6'h07;
  localparam logic [5:0] MODE1_IDX = 6'h08;
  localparam logic [5:0] RDATA_IDX = 6'h09;
  localparam logic [5:0] TDATA_IDX = 6'h0A;
  localparam logic [5:0] EOS_IDX = 6'h0B;
  localparam logic [5:0] STACK_IDX = 6'h0C;
  localparam logic [5:0] STATUS_IDX = 6'h0D;

  // Mode register bits
  localparam int MODE_RX_DMA = 0;
  localparam int MODE_TX_DMA = 1;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [6:0] LEVEL_RESET = 7'h00;
  localparam logic [5:0] LVEC_RESET = 6'h00;

  // Request groups and vector causes
  localparam int GRP_MODEM = 0;
  localparam int GRP_TX = 1;
  localparam int GRP_RX = 2;
  localparam logic [1:0] CAUSE_RX_DATA = 2'h0;
  localparam logic [1:0] CAUSE_MODEM = 2'h1;
  localparam logic [1:0] CAUSE_TX = 2'h2;
  localparam logic [1:0] CAUSE_RX_EXC = 2'h3;

  typedef enum {ACK_IDLE, ACK_KEEP, ACK_PASS} ack_state_t;
endpackage

// File: hdl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // A bit changes only once the second and third stages agree
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      dout <= INIT;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// File: hdl/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo
  import vec_irq_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic rd_ready,
  output logic [CNT_W-1:0] count
);
  logic [7:0] mem [FIFO_DEPTH];
  logic [3:0] wp_r;
  logic [3:0] rp_r;
  logic [CNT_W-1:0] cnt_r;
  logic push;
  logic pop;

  assign wr_ready = (cnt_r != CNT_W'(FIFO_DEPTH));
  assign rd_valid = (cnt_r != '0);
  assign push = wr_valid && wr_ready;
  assign pop = rd_ready && rd_valid;
  assign rd_data = mem[rp_r];
  assign count = cnt_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 4'h1;
      end
      if (pop) begin
        rp_r <= rp_r + 4'h1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 5'h01;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 5'h01;
      end
    end
  end
endmodule

// File: hdl/vectored_interrupt_daisy_chain.sv
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
// Functional notes
// - Three request outputs: modem/timer, transmit, receive.
// - Modem group only for exceptions; transmit and receive also for data.
// - Vector is local vector in upper six bits, cause in low two.
// - Data causes only without DMA; DMA events only in DMA mode.
// - Acknowledge starts with ack-in and strobe low; seven address bits compared.
// - On match drive vector and transfer ack until strobe removed.
// - Request outputs are open drain, only pulling low.
// - Equal levels: receive first, then transmit, then modem.
// - No request asserted: pass acknowledge onward.
// - Requesting but no level match: pass acknowledge onward.
// - Requesting with level match: keep acknowledge and supply vector, unless the three-entry stack is full (then pass).
// - Asserting a request clears its fair bit until the shared line is high.
// - No new request of a type while its fair bit is cleared.
// - Fair sharing is always on, with no enable bit.
// - Each channel has 16-byte receive and transmit FIFOs via shared data registers.
// - One threshold per channel for both FIFOs, at most 12.
// - Threshold triggers DMA bursts in DMA mode, requests otherwise.
// - Context opens at acknowledge, closes with matching end-of-service write.
// - New acknowledge pushes context onto a host-visible stack.
// - Receive data request when receive FIFO count exceeds threshold.
// - Transmit data request when transmit FIFO free space exceeds threshold.
module vectored_interrupt_daisy_chain
  import vec_irq_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic ACK_CHAIN_IN_N,
  input wire logic DATA_STROBE_N,
  input wire logic [6:0] ADDR_LEVEL,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic TRANSFER_ACK_N_OUT,
  output logic TRANSFER_ACK_OE,
  output logic ACK_CHAIN_OUT_N,
  input wire logic MODEM_TIMER_REQUEST_N_IN,
  input wire logic TRANSMIT_REQUEST_N_IN,
  input wire logic RECEIVE_REQUEST_N_IN,
  output logic MODEM_TIMER_REQUEST_N_OUT,
  output logic MODEM_TIMER_REQUEST_OE,
  output logic TRANSMIT_REQUEST_N_OUT,
  output logic TRANSMIT_REQUEST_OE,
  output logic RECEIVE_REQUEST_N_OUT,
  output logic RECEIVE_REQUEST_OE,
  input wire logic [1:0] RX_CHAR_VALID,
  input wire logic [15:0] RX_CHAR,
  output logic [1:0] RX_CHAR_READY,
  output logic [1:0] TX_CHAR_VALID,
  output logic [15:0] TX_CHAR,
  input wire logic [1:0] TX_CHAR_TAKE,
  input wire logic [1:0] RX_EXCEPTION,
  input wire logic [1:0] TX_EXCEPTION,
  input wire logic [1:0] MODEM_EVENT,
  input wire logic [1:0] DMA_RX_EVENT,
  input wire logic [1:0] DMA_TX_EVENT,
  output logic [1:0] DMA_RX_BURST,
  output logic [1:0] DMA_TX_BURST
);
  logic [5:0] lvec_r [NUM_CH];
  logic [6:0] level_r [3];
  logic [3:0] thresh_r [NUM_CH];
  logic [2:0] mode_r [NUM_CH];
  logic [1:0] rx_exc_r;
  logic [1:0] tx_exc_r;
  logic [1:0] modem_exc_r;
  logic [2:0] drive_r;
  logic [2:0] fair_r;
  logic [1:0] stk_grp_r [STACK_DEPTH];
  logic stk_ch_r [STACK_DEPTH];
  logic [1:0] depth_r;
  logic [7:0] vec_r;
  ack_state_t state_r;
  ack_state_t state_nxt;

  logic [SYNC_W-1:0] sync_out;
  logic ack_in_s;
  logic ds_s;
  logic [6:0] level_s;
  logic [2:0] line_s;

  logic [CNT_W-1:0] rx_cnt [NUM_CH];
  logic [CNT_W-1:0] tx_cnt [NUM_CH];
  logic [7:0] rx_head [NUM_CH];
  logic [1:0] rx_pop;
  logic [1:0] tx_push;
  logic [1:0] tx_ready;
  logic [1:0] rx_data_pend;
  logic [1:0] tx_data_pend;
  logic [1:0] pend [3];
  logic [2:0] any_pend;

  logic in_ctx;
  logic top_ch;
  logic [1:0] top_grp;
  logic access;
  logic wr_en;
  logic [5:0] widx;
  logic eos_pop;

  logic [2:0] match;
  logic hit;
  logic [1:0] hit_grp;
  logic hit_ch;
  logic [7:0] hit_vec;

  pin_sync #(.W(SYNC_W), .INIT({SYNC_W{1'b1}})) u_sync (
    .clk(CLK),
    .reset(RESET),
    .din({RECEIVE_REQUEST_N_IN, TRANSMIT_REQUEST_N_IN, MODEM_TIMER_REQUEST_N_IN,
          ADDR_LEVEL, DATA_STROBE_N, ACK_CHAIN_IN_N}),
    .dout(sync_out)
  );
  assign ack_in_s = ~sync_out[0];
  assign ds_s = ~sync_out[1];
  assign level_s = sync_out[8:2];
  assign line_s = sync_out[11:9];

  assign in_ctx = (depth_r != 2'h0);
  assign top_grp = in_ctx ? stk_grp_r[depth_r - 2'h1] : 2'h0;
  assign top_ch = in_ctx ? stk_ch_r[depth_r - 2'h1] : 1'b0;

  // Data registers are live only for the channel in service
  assign access = CYC_I && STB_I && !ACK_O;
  assign wr_en = access && WE_I && SEL_I[0];
  assign widx = ADR_I[7:2];
  assign eos_pop = wr_en && (widx == EOS_IDX) && in_ctx && (DAT_I[1:0] == top_grp);

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    byte_fifo u_rx (
      .clk(CLK),
      .reset(RESET),
      .wr_valid(RX_CHAR_VALID[c]),
      .wr_data(RX_CHAR[c*8 +: 8]),
      .wr_ready(RX_CHAR_READY[c]),
      .rd_valid(),
      .rd_data(rx_head[c]),
      .rd_ready(rx_pop[c]),
      .count(rx_cnt[c])
    );
    byte_fifo u_tx (
      .clk(CLK),
      .reset(RESET),
      .wr_valid(tx_push[c]),
      .wr_data(DAT_I[7:0]),
      .wr_ready(tx_ready[c]),
      .rd_valid(TX_CHAR_VALID[c]),
      .rd_data(TX_CHAR[c*8 +: 8]),
      .rd_ready(TX_CHAR_TAKE[c]),
      .count(tx_cnt[c])
    );
    // shared data registers act only inside a context
    assign rx_pop[c] = access && !WE_I && (widx == RDATA_IDX) && in_ctx && (top_ch == c);
    assign tx_push[c] = wr_en && (widx == TDATA_IDX) && in_ctx && (top_ch == c) && tx_ready[c];

    assign rx_data_pend[c] = !mode_r[c][MODE_RX_DMA] && (rx_cnt[c] > {1'b0, thresh_r[c]});
    assign DMA_RX_BURST[c] = mode_r[c][MODE_RX_DMA] && (rx_cnt[c] > {1'b0, thresh_r[c]});
    assign tx_data_pend[c] = !mode_r[c][MODE_TX_DMA]
                             && ((CNT_W'(FIFO_DEPTH) - tx_cnt[c]) > {1'b0, thresh_r[c]});
    assign DMA_TX_BURST[c] = mode_r[c][MODE_TX_DMA]
                             && ((CNT_W'(FIFO_DEPTH) - tx_cnt[c]) > {1'b0, thresh_r[c]});
  end

  assign pend[GRP_MODEM] = modem_exc_r;
  assign pend[GRP_TX] = tx_exc_r | tx_data_pend;
  assign pend[GRP_RX] = rx_exc_r | rx_data_pend;
  assign any_pend = {|pend[GRP_RX], |pend[GRP_TX], |pend[GRP_MODEM]};

  // Sticky exceptions; a new event wins over the end-of-service clear
  // DMA events count only in DMA mode
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rx_exc_r <= '0;
      tx_exc_r <= '0;
      modem_exc_r <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (eos_pop && (top_ch == c)) begin
          if (top_grp == 2'(GRP_RX)) begin
            rx_exc_r[c] <= 1'b0;
          end
          if (top_grp == 2'(GRP_TX)) begin
            tx_exc_r[c] <= 1'b0;
          end
          if (top_grp == 2'(GRP_MODEM)) begin
            modem_exc_r[c] <= 1'b0;
          end
        end
        if (RX_EXCEPTION[c] || (DMA_RX_EVENT[c] && mode_r[c][MODE_RX_DMA])) begin
          rx_exc_r[c] <= 1'b1;
        end
        if (TX_EXCEPTION[c] || (DMA_TX_EVENT[c] && mode_r[c][MODE_TX_DMA])) begin
          tx_exc_r[c] <= 1'b1;
        end
        if (MODEM_EVENT[c]) begin
          modem_exc_r[c] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      drive_r <= '0;
      fair_r <= '1;
    end else begin
      for (int g = 0; g < 3; g++) begin
        // new request only with fair bit set
        if (fair_r[g] && !drive_r[g]) begin
          drive_r[g] <= any_pend[g];
        end else if (state_r == ACK_IDLE && state_nxt == ACK_KEEP && hit_grp == 2'(g)) begin
          drive_r[g] <= 1'b0;
        end else if (!any_pend[g]) begin
          drive_r[g] <= 1'b0;
        end
        // fair bit cleared while own request drives the line low
        if (drive_r[g]) begin
          fair_r[g] <= 1'b0;
        end else if (line_s[g]) begin
          fair_r[g] <= 1'b1;
        end
      end
    end
  end

  assign MODEM_TIMER_REQUEST_N_OUT = 1'b0;
  assign TRANSMIT_REQUEST_N_OUT = 1'b0;
  assign RECEIVE_REQUEST_N_OUT = 1'b0;
  assign MODEM_TIMER_REQUEST_OE = drive_r[GRP_MODEM];
  assign TRANSMIT_REQUEST_OE = drive_r[GRP_TX];
  assign RECEIVE_REQUEST_OE = drive_r[GRP_RX];

  // level compared against each group register
  always_comb begin
    for (int g = 0; g < 3; g++) begin
      match[g] = drive_r[g] && (level_s == level_r[g]);
    end
  end

  // local vector above the cause code
  always_comb begin
    hit = 1'b1;
    hit_grp = 2'(GRP_RX);
    hit_ch = !pend[GRP_RX][0];
    hit_vec = '0;
    if (match[GRP_RX]) begin
      hit_grp = 2'(GRP_RX);
      hit_ch = !pend[GRP_RX][0];
      hit_vec = {lvec_r[hit_ch], rx_exc_r[hit_ch] ? CAUSE_RX_EXC : CAUSE_RX_DATA};
    end else if (match[GRP_TX]) begin
      hit_grp = 2'(GRP_TX);
      hit_ch = !pend[GRP_TX][0];
      hit_vec = {lvec_r[hit_ch], CAUSE_TX};
    end else if (match[GRP_MODEM]) begin
      hit_grp = 2'(GRP_MODEM);
      hit_ch = !pend[GRP_MODEM][0];
      hit_vec = {lvec_r[hit_ch], CAUSE_MODEM};
    end else begin
      hit = 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ACK_IDLE: begin
        if (ack_in_s && ds_s) begin
          state_nxt = (hit && depth_r != 2'(STACK_DEPTH)) ? ACK_KEEP : ACK_PASS;
        end
      end
      ACK_KEEP: begin
        if (!ds_s) begin
          state_nxt = ACK_IDLE;
        end
      end
      ACK_PASS: begin
        // release pass on ack-in or strobe high
        if (!ack_in_s || !ds_s) begin
          state_nxt = ACK_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_r <= ACK_IDLE;
      vec_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ACK_IDLE && state_nxt == ACK_KEEP) begin
        vec_r <= hit_vec;
      end
    end
  end

  // vector and transfer ack while kept
  assign DATA_OUT = vec_r;
  assign DATA_OE = (state_r == ACK_KEEP);
  assign TRANSFER_ACK_N_OUT = 1'b0;
  assign TRANSFER_ACK_OE = (state_r == ACK_KEEP);
  assign ACK_CHAIN_OUT_N = (state_r != ACK_PASS);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      depth_r <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stk_grp_r[i] <= '0;
        stk_ch_r[i] <= 1'b0;
      end
    end else if (state_r == ACK_IDLE && state_nxt == ACK_KEEP) begin
      stk_grp_r[depth_r] <= hit_grp;
      stk_ch_r[depth_r] <= hit_ch;
      depth_r <= depth_r + 2'h1;
    end else if (eos_pop) begin
      depth_r <= depth_r - 2'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int c = 0; c < NUM_CH; c++) begin
        lvec_r[c] <= LVEC_RESET;
        thresh_r[c] <= THRESH_RESET;
        mode_r[c] <= MODE_RESET;
      end
      for (int g = 0; g < 3; g++) begin
        level_r[g] <= LEVEL_RESET;
      end
    end else if (wr_en) begin
      unique case (widx)
        LVEC0_IDX: lvec_r[0] <= DAT_I[7:2];
        LVEC1_IDX: lvec_r[1] <= DAT_I[7:2];
        RX_LEVEL_IDX: level_r[GRP_RX] <= DAT_I[6:0];
        TX_LEVEL_IDX: level_r[GRP_TX] <= DAT_I[6:0];
        MODEM_LEVEL_IDX: level_r[GRP_MODEM] <= DAT_I[6:0];
        OPT4_0_IDX: thresh_r[0] <= (DAT_I[3:0] > THRESH_MAX) ? THRESH_MAX : DAT_I[3:0];
        OPT4_1_IDX: thresh_r[1] <= (DAT_I[3:0] > THRESH_MAX) ? THRESH_MAX : DAT_I[3:0];
        MODE0_IDX: mode_r[0] <= DAT_I[2:0];
        MODE1_IDX: mode_r[1] <= DAT_I[2:0];
        default: begin
        end
      endcase
    end
  end

  // One wait state: ack and read data one edge after the request
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ACK_O <= 1'b0;
      DAT_O <= '0;
    end else begin
      ACK_O <= access;
      if (access && !WE_I) begin
        unique case (widx)
          LVEC0_IDX: DAT_O <= {24'h000000, lvec_r[0], 2'h0};
          LVEC1_IDX: DAT_O <= {24'h000000, lvec_r[1], 2'h0};
          RX_LEVEL_IDX: DAT_O <= {25'h0, level_r[GRP_RX]};
          TX_LEVEL_IDX: DAT_O <= {25'h0, level_r[GRP_TX]};
          MODEM_LEVEL_IDX: DAT_O <= {25'h0, level_r[GRP_MODEM]};
          OPT4_0_IDX: DAT_O <= {28'h0000000, thresh_r[0]};
          OPT4_1_IDX: DAT_O <= {28'h0000000, thresh_r[1]};
          MODE0_IDX: DAT_O <= {29'h0, mode_r[0]};
          MODE1_IDX: DAT_O <= {29'h0, mode_r[1]};
          RDATA_IDX: DAT_O <= in_ctx ? {24'h000000, rx_head[top_ch]} : 32'h00000000;
          STACK_IDX: DAT_O <= {19'h0, stk_ch_r[2], stk_grp_r[2], stk_ch_r[1], stk_grp_r[1],
                               stk_ch_r[0], stk_grp_r[0], 2'h0, depth_r};
          STATUS_IDX: DAT_O <= {6'h00, rx_cnt[1], rx_cnt[0], tx_cnt[1], tx_cnt[0],
                                fair_r, drive_r};
          default: DAT_O <= 32'h00000000;
        endcase
      end else begin
        DAT_O <= 32'h00000000;
      end
    end
  end
endmodule

// File: dv/vec_irq_monitor.sv
`timescale 1ns/1ps
module vec_irq_monitor
  import vec_irq_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  input wire logic ACK_CHAIN_IN_N,
  input wire logic DATA_STROBE_N,
  input wire logic DATA_OE,
  input wire logic TRANSFER_ACK_N_OUT,
  input wire logic TRANSFER_ACK_OE,
  input wire logic ACK_CHAIN_OUT_N,
  input wire logic MODEM_TIMER_REQUEST_N_IN,
  input wire logic TRANSMIT_REQUEST_N_IN,
  input wire logic RECEIVE_REQUEST_N_IN,
  input wire logic MODEM_TIMER_REQUEST_N_OUT,
  input wire logic MODEM_TIMER_REQUEST_OE,
  input wire logic TRANSMIT_REQUEST_N_OUT,
  input wire logic TRANSMIT_REQUEST_OE,
  input wire logic RECEIVE_REQUEST_N_OUT,
  input wire logic RECEIVE_REQUEST_OE
);
  logic [2:0] oe;
  logic [2:0] line;
  logic [2:0] seen_high_r;
  assign oe = {RECEIVE_REQUEST_OE, TRANSMIT_REQUEST_OE, MODEM_TIMER_REQUEST_OE};
  assign line = {RECEIVE_REQUEST_N_IN, TRANSMIT_REQUEST_N_IN, MODEM_TIMER_REQUEST_N_IN};
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // Raw pin leads the synced copy, so this can only be more permissive than the design
  always_ff @(posedge CLK) begin
    if (RESET) begin
      seen_high_r <= 3'h7;
    end else begin
      seen_high_r <= (seen_high_r | (line & ~oe)) & ~oe;
    end
  end
  chk_drain_low: assert property (
    MODEM_TIMER_REQUEST_N_OUT == 1'b0 && TRANSMIT_REQUEST_N_OUT == 1'b0
    && RECEIVE_REQUEST_N_OUT == 1'b0 && TRANSFER_ACK_N_OUT == 1'b0) else $error("open drain drives high");
  chk_keep_or_pass: assert property (
    !(DATA_OE && !ACK_CHAIN_OUT_N)) else $error("kept and passed at once");
  chk_vector_with_ack: assert property (
    DATA_OE == TRANSFER_ACK_OE) else $error("vector without transfer ack");
  chk_start_on_pins: assert property (
    ($rose(TRANSFER_ACK_OE) || $fell(ACK_CHAIN_OUT_N)) |-> $past(!ACK_CHAIN_IN_N && !DATA_STROBE_N, 3))
    else $error("acknowledge answered without ack-in and strobe");
  chk_keep_needs_req: assert property (
    $rose(DATA_OE) |-> $past(|oe)) else $error("kept with no request driven");
  chk_hold_on_strobe: assert property (
    TRANSFER_ACK_OE && !DATA_STROBE_N |=> TRANSFER_ACK_OE && DATA_OE) else $error("ack dropped under strobe");
  chk_strobe_release: assert property (
    DATA_STROBE_N [*8] |-> !TRANSFER_ACK_OE && ACK_CHAIN_OUT_N) else $error("ack not released");
  chk_bus_answer: assert property (
    CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O) else $error("bus ack not a one-cycle pulse");
  for (genvar g = 0; g < 3; g++) begin : g_fair
    chk_fair_hold: assert property (
      $rose(oe[g]) |-> $past(seen_high_r[g])) else $error("request raised before line went high");
  end
endmodule

bind vectored_interrupt_daisy_chain vec_irq_monitor i_vec_irq_monitor (.CLK(CLK), .RESET(RESET),
  .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .ACK_CHAIN_IN_N(ACK_CHAIN_IN_N), .DATA_STROBE_N(DATA_STROBE_N),
  .DATA_OE(DATA_OE), .TRANSFER_ACK_N_OUT(TRANSFER_ACK_N_OUT), .TRANSFER_ACK_OE(TRANSFER_ACK_OE),
  .ACK_CHAIN_OUT_N(ACK_CHAIN_OUT_N), .MODEM_TIMER_REQUEST_N_IN(MODEM_TIMER_REQUEST_N_IN),
  .TRANSMIT_REQUEST_N_IN(TRANSMIT_REQUEST_N_IN), .RECEIVE_REQUEST_N_IN(RECEIVE_REQUEST_N_IN),
  .MODEM_TIMER_REQUEST_N_OUT(MODEM_TIMER_REQUEST_N_OUT), .MODEM_TIMER_REQUEST_OE(MODEM_TIMER_REQUEST_OE),
  .TRANSMIT_REQUEST_N_OUT(TRANSMIT_REQUEST_N_OUT), .TRANSMIT_REQUEST_OE(TRANSMIT_REQUEST_OE),
  .RECEIVE_REQUEST_N_OUT(RECEIVE_REQUEST_N_OUT), .RECEIVE_REQUEST_OE(RECEIVE_REQUEST_OE));

// File: dv/vec_irq_host.sv
`timescale 1ns/1ps
module vec_irq_host (
  input wire logic clk,
  output logic ack_in_n,
  output logic strobe_n,
  output logic [6:0] level,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic tack_oe,
  input wire logic chain_out_n,
  input wire logic [2:0] req_oe,
  input wire logic [2:0] other_pull,
  output logic [2:0] req_line
);
  logic [7:0] bus_last = 8'h00;
  logic [7:0] bus;
  // Shared lines with pull-ups, another chained device may pull too
  assign req_line = ~(req_oe | other_pull);
  // Released data bus shows the inverse of its last value
  assign bus = data_oe ? data_out : ~bus_last;
  always @(posedge clk) begin
    if (data_oe) begin
      bus_last <= data_out;
    end
  end
  initial begin
    ack_in_n = 1'b1;
    strobe_n = 1'b1;
    level = 7'h7F;
  end
  // Read-like cycle, vector taken before any other access
  task automatic ack_cycle(input logic [6:0] lvl, output logic kept, output logic [7:0] vec, output logic done);
    int n;
    kept = 1'b0;
    vec = 8'h00;
    done = 1'b0;
    @(posedge clk);
    ack_in_n <= 1'b0;
    strobe_n <= 1'b0;
    level <= lvl;
    for (n = 0; n < 30 && !done; n++) begin
      @(posedge clk);
      if (tack_oe === 1'b1) begin
        kept = 1'b1;
        vec = bus;
        done = 1'b1;
      end else if (chain_out_n === 1'b0) begin
        done = 1'b1;
      end
    end
    ack_in_n <= 1'b1;
    strobe_n <= 1'b1;
    level <= ~lvl;
    for (n = 0; n < 30 && (tack_oe !== 1'b0 || chain_out_n !== 1'b1); n++) begin
      @(posedge clk);
    end
    done = done && n < 30;
    repeat (2) @(posedge clk);
  endtask
endmodule

// File: dv/vectored_interrupt_daisy_chain_bench.sv
`timescale 1ns/1ps
module vectored_interrupt_daisy_chain_bench
  import vec_irq_pkg::*;
();
  localparam logic [7:0] LV0 = 8'hA4;
  localparam logic [7:0] LV1 = 8'h58;
  logic CLK, RESET, CYC_I, STB_I, WE_I, ACK_O, ACK_CHAIN_IN_N, DATA_STROBE_N;
  logic DATA_OE, TRANSFER_ACK_OE, ACK_CHAIN_OUT_N;
  logic [7:0] ADR_I;
  logic [7:0] DATA_OUT;
  logic [6:0] ADDR_LEVEL;
  logic [3:0] SEL_I;
  logic [31:0] DAT_I, DAT_O;
  logic [2:0] req_line, req_oe, other_pull;
  logic [1:0] RX_CHAR_VALID, RX_CHAR_READY, MODEM_EVENT, DMA_RX_BURST, DMA_TX_BURST;
  logic [15:0] RX_CHAR;
  int n_fail = 0;
  int samples_checked = 0;
  vectored_interrupt_daisy_chain i_vectored_interrupt_daisy_chain (.CLK(CLK), .RESET(RESET),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
    .ACK_O(ACK_O), .ACK_CHAIN_IN_N(ACK_CHAIN_IN_N), .DATA_STROBE_N(DATA_STROBE_N), .ADDR_LEVEL(ADDR_LEVEL),
    .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .TRANSFER_ACK_N_OUT(), .TRANSFER_ACK_OE(TRANSFER_ACK_OE),
    .ACK_CHAIN_OUT_N(ACK_CHAIN_OUT_N), .MODEM_TIMER_REQUEST_N_IN(req_line[0]),
    .TRANSMIT_REQUEST_N_IN(req_line[1]), .RECEIVE_REQUEST_N_IN(req_line[2]), .MODEM_TIMER_REQUEST_N_OUT(),
    .MODEM_TIMER_REQUEST_OE(req_oe[0]), .TRANSMIT_REQUEST_N_OUT(), .TRANSMIT_REQUEST_OE(req_oe[1]),
    .RECEIVE_REQUEST_N_OUT(), .RECEIVE_REQUEST_OE(req_oe[2]), .RX_CHAR_VALID(RX_CHAR_VALID),
    .RX_CHAR(RX_CHAR), .RX_CHAR_READY(RX_CHAR_READY), .TX_CHAR_VALID(), .TX_CHAR(), .TX_CHAR_TAKE(2'b00),
    .RX_EXCEPTION(2'b00), .TX_EXCEPTION(2'b00), .MODEM_EVENT(MODEM_EVENT), .DMA_RX_EVENT(2'b00),
    .DMA_TX_EVENT(2'b00), .DMA_RX_BURST(DMA_RX_BURST), .DMA_TX_BURST(DMA_TX_BURST));
  vec_irq_host i_vec_irq_host (.clk(CLK), .ack_in_n(ACK_CHAIN_IN_N), .strobe_n(DATA_STROBE_N),
    .level(ADDR_LEVEL), .data_out(DATA_OUT), .data_oe(DATA_OE), .tack_oe(TRANSFER_ACK_OE),
    .chain_out_n(ACK_CHAIN_OUT_N), .req_oe(req_oe), .other_pull(other_pull), .req_line(req_line));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    @(posedge CLK);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= {idx, 2'b00};
    DAT_I <= wd;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (ACK_O !== 1'b1 && n < 20);
    rdat = DAT_O;
    chk(ACK_O, 1);
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
    DAT_I <= ~wd;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, idx, d, r);
  endtask
  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, idx, 32'h0, r);
    chk(r & mask, exp);
  endtask
  task automatic ack(input logic [6:0] lvl, input logic k, input logic [7:0] v);
    logic kept, done;
    logic [7:0] vec;
    i_vec_irq_host.ack_cycle(lvl, kept, vec, done);
    chk({done, kept}, {1'b1, k});
    if (k) chk(vec, v);
  endtask
  task automatic wait_oe(input int g, input logic v, input int lim);
    for (int n = 0; n < lim && req_oe[g] !== v; n++) @(posedge CLK);
    chk(req_oe[g], v);
  endtask
  task automatic push_rx(input logic [7:0] b);
    @(posedge CLK);
    RX_CHAR_VALID <= 2'b10;
    RX_CHAR <= {b, 8'h00};
    do @(posedge CLK); while (RX_CHAR_READY[1] !== 1'b1);
    RX_CHAR_VALID <= 2'b00;
    RX_CHAR <= {~b, 8'hFF};
  endtask
  initial begin
    repeat (30000) @(posedge CLK);
    n_fail++;
    $display("watchdog expired");
    print_verdict();
  end
  initial begin
    logic [7:0] expv [3];
    int grp [3];
    {RESET, CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} = {1'b1, 3'h0, 8'h00, 4'hF, 32'h0};
    {other_pull, RX_CHAR_VALID, RX_CHAR, MODEM_EVENT} = {3'h0, 2'h0, 16'h0, 2'h0};
    repeat (20) @(posedge CLK);
    RESET <= 1'b0;
    repeat (4) @(posedge CLK);
    chk(req_oe, 3'b010);
    wr(OPT4_0_IDX, 32'hF);
    rd_chk(OPT4_0_IDX, 32'hF, {28'h0, THRESH_MAX});
    wr(OPT4_0_IDX, 32'h8);
    rd_chk(6'h3F, 32'hFFFFFFFF, 32'h0);
    rd_chk(RDATA_IDX, 32'hFF, 32'h0);
    wr(LVEC0_IDX, LV0);
    wr(LVEC1_IDX, LV1);
    wr(RX_LEVEL_IDX, 32'h11);
    wr(TX_LEVEL_IDX, 32'h22);
    wr(MODEM_LEVEL_IDX, 32'h33);
    $display("test setup done");
    ack(7'h05, 1'b0, 8'h00);
    ack(7'h22, 1'b1, {LV0[7:2], CAUSE_TX});
    rd_chk(STACK_IDX, 32'h3, 32'h1);
    wr(EOS_IDX, GRP_TX);
    rd_chk(STACK_IDX, 32'h3, 32'h0);
    $display("test keep_and_pass done");
    wr(MODE0_IDX, 32'h2);
    wr(MODE1_IDX, 32'h2);
    wait_oe(GRP_TX, 1'b0, 10);
    chk(DMA_TX_BURST, 2'b11);
    ack(7'h22, 1'b0, 8'h00);
    wr(MODE0_IDX, 32'h0);
    wr(MODE1_IDX, 32'h0);
    chk(DMA_TX_BURST, 2'b00);
    $display("test dma_mode done");
    wr(TX_LEVEL_IDX, 32'h11);
    wr(MODEM_LEVEL_IDX, 32'h11);
    for (int i = 0; i < 8; i++) push_rx(8'h30 + i[7:0]);
    repeat (8) @(posedge CLK);
    chk(req_oe[GRP_RX], 1'b0);
    push_rx(8'h38);
    wr(MODE1_IDX, 32'h1);
    chk(DMA_RX_BURST, 2'b10);
    wr(MODE1_IDX, 32'h0);
    wait_oe(GRP_RX, 1'b1, 10);
    MODEM_EVENT <= 2'b01;
    @(posedge CLK);
    MODEM_EVENT <= 2'b00;
    wait_oe(GRP_MODEM, 1'b1, 10);
    wait_oe(GRP_TX, 1'b1, 10);
    expv = '{{LV1[7:2], CAUSE_RX_DATA}, {LV0[7:2], CAUSE_TX}, {LV0[7:2], CAUSE_MODEM}};
    grp = '{GRP_RX, GRP_TX, GRP_MODEM};
    for (int i = 0; i < 3; i++) begin
      ack(7'h11, 1'b1, expv[i]);
      if (i == 0) rd_chk(RDATA_IDX, 32'hFF, 32'h30);
      wr(EOS_IDX, grp[i]);
      // Transmit data stays pending and re-raises, so move it off the shared level
      if (i == 1) wr(TX_LEVEL_IDX, 32'h22);
    end
    $display("test priority done");
    wr(MODEM_LEVEL_IDX, 32'h33);
    other_pull <= 3'b001;
    MODEM_EVENT <= 2'b10;
    @(posedge CLK);
    MODEM_EVENT <= 2'b00;
    wait_oe(GRP_MODEM, 1'b1, 10);
    ack(7'h33, 1'b1, {LV1[7:2], CAUSE_MODEM});
    wr(EOS_IDX, GRP_MODEM);
    MODEM_EVENT <= 2'b10;
    @(posedge CLK);
    MODEM_EVENT <= 2'b00;
    repeat (12) @(posedge CLK);
    // No enable was ever written, so sharing must already be in force
    chk(req_oe[GRP_MODEM], 1'b0);
    other_pull <= 3'b000;
    wait_oe(GRP_MODEM, 1'b1, 12);
    ack(7'h33, 1'b1, {LV1[7:2], CAUSE_MODEM});
    wr(EOS_IDX, GRP_MODEM);
    $display("test fair_share done");
    print_verdict();
  end
endmodule
